// *** rtl/pin_cell.sv ***
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pin_cell_regs.svh"

// Functional notes
// - Each element selectable flip-flop or latch
// - One shared clock, separate enable per element
// - Shared set/reset: sync set/reset, async preset/clear
// - Output and every control signal independently invertible
// - Before configuration outputs float, pull-down/keeper off; in boundary-scan mode (bs.mode) the code drives pad_oe from bs.oe
// - Mode pin decides pre-configuration pull-ups globally
// - Pin cell supports boundary-scan testing
// - Input delivered direct, registered, or both
// - Optional delay in front of input register
// - Pad data direct or from output register
// - Three-state control direct or from register
// - Per-buffer standard, drive strength and slew select
// - Keeper weakly follows pad, holds last level
// - Optional pull-up or pull-down after configuration
module pin_cell (
	input  wire logic                    mclk,
	input  wire logic                    arst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    pad_in,
	output logic                         pad_out,
	output logic                         pad_oe,
	output logic                         keep_out,
	output logic                         keep_oe,
	output logic                         pull_up_en,
	output logic                         pull_dn_en,
	input  wire logic                    mode_pullup,
	input  wire pin_cell_pkg::fab_in_t   fab,
	output pin_cell_pkg::fab_out_t       fab_i,
	input  wire pin_cell_pkg::bscan_t    bs,
	output logic                         bs_capture,
	output logic      [3:0]              io_std,
	output logic      [2:0]              drive,
	output logic                         slew_fast
);

	pin_cell_pkg::state_t s_q;
	pin_cell_pkg::state_t s_d;
	logic                 clk_lvl;
	logic                 edg;
	logic                 sr_act;
	logic [2:0]           ce_eff;
	logic [2:0]           d_in;
	logic                 t_eff;
	logic                 o_eff;
	logic                 setup;
	logic                 acc;
	logic                 hit;
	logic [31:0]          wm;

	// Next value of one storage element
	function automatic logic elem_next(
		input logic                   q,
		input logic                   d,
		input logic                   ce,
		input logic                   latch,
		input pin_cell_pkg::sr_mode_t mode,
		input logic                   sr,
		input logic                   lvl,
		input logic                   ed
	);
		logic act;
		act = latch ? lvl : ed;
		if (sr && mode == pin_cell_pkg::SR_ASYNC_PRE) begin
			return 1'h1;
		end
		if (sr && mode == pin_cell_pkg::SR_ASYNC_CLR) begin
			return 1'h0;
		end
		if (act && sr) begin
			return (mode == pin_cell_pkg::SR_SYNC_SET);
		end
		if (act && ce) begin
			return d;
		end
		return q;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.pad_m = pad_in;
		s_d.pad_s = s_q.pad_m;
		s_d.mode_m = mode_pullup;
		s_d.mode_s = s_q.mode_m;
		clk_lvl = fab.clk ^ s_q.ctrl.inv_clk;
		edg = clk_lvl & ~s_q.clk_prev;
		s_d.clk_prev = clk_lvl;
		sr_act = fab.sr ^ s_q.ctrl.inv_sr;
		ce_eff = fab.ce ^ s_q.ctrl.inv_ce;
		s_d.pad_dly = s_q.pad_s;
		d_in[`PC_EL_IN] = s_q.ctrl.in_dly ? s_q.pad_dly : s_q.pad_s;
		d_in[`PC_EL_OUT] = fab.o;
		d_in[`PC_EL_OE] = fab.t ^ s_q.ctrl.inv_t;
		for (int k = 0; k < `PC_NUM_EL; k++) begin
			s_d.elem[k] = elem_next(s_q.elem[k], d_in[k], ce_eff[k],
				s_q.ctrl.latch[k], s_q.ctrl.sr_mode[k], sr_act, clk_lvl, edg);
		end
		t_eff = s_q.ctrl.t_reg ? s_q.elem[`PC_EL_OE] : d_in[`PC_EL_OE];
		o_eff = (s_q.ctrl.o_reg ? s_q.elem[`PC_EL_OUT] : fab.o) ^ s_q.ctrl.inv_o;
		if (bs.mode) begin
			s_d.pad_out = bs.o;
			s_d.pad_oe = bs.oe;
		end else if (!s_q.ctrl.done) begin
			s_d.pad_out = 1'h0;
			s_d.pad_oe = 1'h0;
		end else begin
			s_d.pad_out = o_eff;
			s_d.pad_oe = ~t_eff;
		end
		s_d.keep_oe = s_q.ctrl.done & s_q.ctrl.keeper_en & ~s_d.pad_oe;
		s_d.keep_out = s_q.pad_s;
		s_d.pull_up = s_q.ctrl.done ? s_q.ctrl.pull_up : s_q.mode_s;
		s_d.pull_dn = s_q.ctrl.done & s_q.ctrl.pull_dn;
		s_d.fab_i = s_q.pad_s;
		setup = psel & ~penable;
		acc = psel & penable;
		hit = (paddr == `PC_CTRL_OFS) || (paddr == `PC_BUF_OFS) ||
			(paddr == `PC_STAT_OFS);
		wm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		if (setup && !pwrite) begin
			case (paddr)
				`PC_CTRL_OFS: s_d.prdata = s_q.ctrl;
				`PC_BUF_OFS:  s_d.prdata = s_q.bufc;
				`PC_STAT_OFS: s_d.prdata = pin_cell_pkg::stat_t'({25'h0, s_q.mode_s,
					s_q.keep_oe, s_q.pad_oe, s_q.elem, s_q.pad_s});
				default:      s_d.prdata = 32'h0000_0000;
			endcase
		end
		if (acc && pwrite && paddr == `PC_CTRL_OFS) begin
			s_d.ctrl = pin_cell_pkg::ctrl_t'((s_q.ctrl & ~(wm & `PC_CTRL_WMASK)) |
				(pwdata & wm & `PC_CTRL_WMASK));
		end
		if (acc && pwrite && paddr == `PC_BUF_OFS) begin
			s_d.bufc = pin_cell_pkg::buf_t'((s_q.bufc & ~(wm & `PC_BUF_WMASK)) |
				(pwdata & wm & `PC_BUF_WMASK));
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.ctrl <= pin_cell_pkg::ctrl_t'(`PC_CTRL_RST);
			s_q.bufc <= pin_cell_pkg::buf_t'(`PC_BUF_RST);
		end else begin
			s_q <= s_d;
		end
	end

	assign pready = 1'h1;
	assign pslverr = acc & ~hit;
	assign prdata = s_q.prdata;
	assign pad_out = s_q.pad_out;
	assign pad_oe = s_q.pad_oe;
	assign keep_out = s_q.keep_out;
	assign keep_oe = s_q.keep_oe;
	assign pull_up_en = s_q.pull_up;
	assign pull_dn_en = s_q.pull_dn;
	assign fab_i = {s_q.fab_i, s_q.elem[`PC_EL_IN]};
	assign bs_capture = s_q.pad_s;
	assign io_std = s_q.bufc.io_std;
	assign drive = s_q.bufc.drive;
	assign slew_fast = s_q.bufc.slew_fast;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	sequence s_in_load;
		s_q.ctrl.latch[`PC_EL_IN] && clk_lvl && ce_eff[`PC_EL_IN] && !sr_act;
	endsequence
	sequence s_out_edge;
		!s_q.ctrl.latch[`PC_EL_OUT] && edg && ce_eff[`PC_EL_OUT] && !sr_act;
	endsequence
	sequence s_buf_wr;
		psel && penable && pwrite && paddr == `PC_BUF_OFS && pstrb[0];
	endsequence

	property p_latch;
		s_in_load |=> s_q.elem[`PC_EL_IN] == $past(d_in[`PC_EL_IN]);
	endproperty
	a_latch: assert property (p_latch) else $error("latch not transparent");

	property p_ff_edge;
		s_out_edge |=> s_q.elem[`PC_EL_OUT] == $past(fab.o);
	endproperty
	a_ff_edge: assert property (p_ff_edge) else $error("flop missed edge");

	property p_ff_hold;
		!s_q.ctrl.latch[`PC_EL_OUT] && !edg &&
			!(sr_act && s_q.ctrl.sr_mode[`PC_EL_OUT][1]) |=> $stable(s_q.elem[`PC_EL_OUT]);
	endproperty
	a_ff_hold: assert property (p_ff_hold) else $error("flop changed off edge");

	property p_async_clr;
		sr_act && s_q.ctrl.sr_mode[`PC_EL_OE] == pin_cell_pkg::SR_ASYNC_CLR
			|=> !s_q.elem[`PC_EL_OE];
	endproperty
	a_async_clr: assert property (p_async_clr) else $error("async clear failed");

	property p_pre_cfg;
		!s_q.ctrl.done && !bs.mode |=> !pad_oe && !pull_dn_en && !keep_oe;
	endproperty
	a_pre_cfg: assert property (p_pre_cfg) else $error("driving before config");

	property p_mode_pull;
		!s_q.ctrl.done |=> pull_up_en == $past(s_q.mode_s);
	endproperty
	a_mode_pull: assert property (p_mode_pull) else $error("pull-up not from mode");

	property p_direct;
		1'h1 |-> ##3 fab_i.i_direct == $past(pad_in, 3);
	endproperty
	a_direct: assert property (p_direct) else $error("direct input wrong");

	property p_delay;
		s_q.ctrl.in_dly |-> d_in[`PC_EL_IN] == $past(pad_in, 3);
	endproperty
	a_delay: assert property (p_delay) else $error("input delay wrong");

	property p_oreg;
		s_q.ctrl.done && s_q.ctrl.o_reg && !bs.mode
			|=> pad_out == ($past(s_q.elem[`PC_EL_OUT]) ^ $past(s_q.ctrl.inv_o));
	endproperty
	a_oreg: assert property (p_oreg) else $error("registered output wrong");

	property p_treg;
		s_q.ctrl.done && s_q.ctrl.t_reg && !bs.mode
			|=> pad_oe == !$past(s_q.elem[`PC_EL_OE]);
	endproperty
	a_treg: assert property (p_treg) else $error("registered enable wrong");

	property p_keep;
		s_q.ctrl.done && s_q.ctrl.keeper_en
			|=> keep_oe == !pad_oe && keep_out == $past(s_q.pad_s);
	endproperty
	a_keep: assert property (p_keep) else $error("keeper wrong");

	property p_bscan;
		bs.mode |=> pad_out == $past(bs.o) && pad_oe == $past(bs.oe);
	endproperty
	a_bscan: assert property (p_bscan) else $error("scan override wrong");

	property p_std;
		s_buf_wr |=> io_std == $past(pwdata[3:0]);
	endproperty
	a_std: assert property (p_std) else $error("standard select wrong");

	property p_pulls;
		s_q.ctrl.done |=> pull_up_en == $past(s_q.ctrl.pull_up) &&
			pull_dn_en == $past(s_q.ctrl.pull_dn);
	endproperty
	a_pulls: assert property (p_pulls) else $error("pull select wrong");

endmodule // pin_cell

// *** rtl/pin_cell_regs.svh ***
`ifndef PIN_CELL_REGS_SVH
`define PIN_CELL_REGS_SVH

// Register byte offsets
`define PC_CTRL_OFS   12'h000
`define PC_BUF_OFS    12'h004
`define PC_STAT_OFS   12'h008

// Reset values and writable bits
`define PC_CTRL_RST   32'h0000_0000
`define PC_BUF_RST    32'h0000_0000
`define PC_CTRL_WMASK 32'h007F_FFFF
`define PC_BUF_WMASK  32'h0000_00FF

// Storage element indices
`define PC_EL_IN      0
`define PC_EL_OUT     1
`define PC_EL_OE      2
`define PC_NUM_EL     3

`endif

// *** rtl/pin_cell_pkg.sv ***
package pin_cell_pkg;

	typedef enum logic [1:0] {
		SR_SYNC_SET,
		SR_SYNC_RST,
		SR_ASYNC_PRE,
		SR_ASYNC_CLR
	} sr_mode_t;

	// Control word, element 0 input, 1 output, 2 output enable
	typedef struct packed {
		logic [8:0]          rsvd;
		logic                done;
		logic                keeper_en;
		logic                pull_dn;
		logic                pull_up;
		logic                in_dly;
		logic                t_reg;
		logic                o_reg;
		logic                inv_o;
		logic                inv_t;
		logic                inv_sr;
		logic [2:0]          inv_ce;
		logic                inv_clk;
		sr_mode_t [2:0]      sr_mode;
		logic [2:0]          latch;
	} ctrl_t;

	typedef struct packed {
		logic [23:0] rsvd;
		logic        slew_fast;
		logic [2:0]  drive;
		logic [3:0]  io_std;
	} buf_t;

	typedef struct packed {
		logic [24:0] rsvd;
		logic        mode_s;
		logic        keep_oe;
		logic        pad_oe;
		logic [2:0]  elem;
		logic        pad_s;
	} stat_t;

	typedef struct packed {
		logic       clk;
		logic [2:0] ce;
		logic       sr;
		logic       o;
		logic       t;
	} fab_in_t;

	typedef struct packed {
		logic i_direct;
		logic i_reg;
	} fab_out_t;

	typedef struct packed {
		logic mode;
		logic o;
		logic oe;
	} bscan_t;

	typedef struct packed {
		logic        pad_m;
		logic        pad_s;
		logic        mode_m;
		logic        mode_s;
		logic        pad_dly;
		logic        clk_prev;
		ctrl_t       ctrl;
		buf_t        bufc;
		logic [2:0]  elem;
		logic        pad_out;
		logic        pad_oe;
		logic        keep_out;
		logic        keep_oe;
		logic        pull_up;
		logic        pull_dn;
		logic        fab_i;
		logic [31:0] prdata;
	} state_t;

endpackage

// *** testbench/pad_partner.sv ***
`timescale 1ns/1ps
module pad_partner (
	input  wire logic mclk,
	input  wire logic pad_out,
	input  wire logic pad_oe,
	input  wire logic keep_out,
	input  wire logic keep_oe,
	input  wire logic pull_up_en,
	input  wire logic pull_dn_en,
	input  wire logic ext_oe,
	input  wire logic ext_val,
	output logic      pad_in
);
	logic flt_q = 1'h0;
	// Undriven pad wanders instead of holding a value
	always_ff @(posedge mclk) flt_q <= ~pad_in;
	always_comb begin
		if (pad_oe) pad_in = pad_out;
		else if (ext_oe) pad_in = ext_val;
		else if (keep_oe) pad_in = keep_out;
		else if (pull_up_en) pad_in = 1'h1;
		else if (pull_dn_en) pad_in = 1'h0;
		else pad_in = flt_q;
	end
endmodule // pad_partner

// *** testbench/configurable_io_block_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module configurable_io_block_tb_top;
	logic                   mclk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic                   pad_in, pad_out, pad_oe, keep_out, keep_oe, pull_up_en, pull_dn_en;
	logic                   mode_pullup, bs_capture, slew_fast, ext_oe, ext_val;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rd;
	logic [3:0]             pstrb, io_std;
	logic [2:0]             drive;
	int                     num_errors = 0;
	int                     checks_done = 0;
	pin_cell_pkg::fab_in_t  fab;
	pin_cell_pkg::fab_out_t fab_i;
	pin_cell_pkg::bscan_t   bs;
	pin_cell_pkg::ctrl_t    c;

	always #2.5 mclk = ~mclk;

	pin_cell dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.keep_out(keep_out), .keep_oe(keep_oe), .pull_up_en(pull_up_en),
		.pull_dn_en(pull_dn_en), .mode_pullup(mode_pullup), .fab(fab), .fab_i(fab_i), .bs(bs),
		.bs_capture(bs_capture), .io_std(io_std), .drive(drive), .slew_fast(slew_fast));

	pad_partner pad (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .keep_out(keep_out),
		.keep_oe(keep_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_oe(ext_oe),
		.ext_val(ext_val), .pad_in(pad_in));

	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (n >= 16) begin
			num_errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic setc;
		apb(1'h1, 12'h000, c);
		tk(4);
	endtask

	task automatic fclk;
		@(posedge mclk);
		fab.clk <= 1'h1;
		tk(3);
		fab.clk <= 1'h0;
		tk(4);
	endtask

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		#400000;
		num_errors++;
		give_verdict();
	end

	initial begin
		mclk = 0;
		arst_n = 0;
		{psel, penable, pwrite, paddr, pwdata, ext_oe, ext_val} = '0;
		pstrb = 4'hF;
		mode_pullup = 1;
		fab = 7'h02;
		bs = 3'h0;
		tk(2);
		arst_n <= 1'h1;
		tk(6);
		`CHK("pad_oe", 1'h0, pad_oe)
		`CHK("pull_dn", 1'h0, pull_dn_en)
		`CHK("keep_oe", 1'h0, keep_oe)
		`CHK("pull_up", 1'h1, pull_up_en)
		mode_pullup <= 1'h0;
		tk(6);
		`CHK("pull_up", 1'h0, pull_up_en)
		apb(1'h0, 12'h000, 32'h0);
		`CHK("ctrl", 32'h0, rd)
		apb(1'h0, 12'h00C, 32'h0);
		`CHK("slverr", 1'h1, err)
		bs <= 3'h7;
		tk(4);
		`CHK("bs_oe", 1'h1, pad_oe)
		`CHK("bs_out", 1'h1, pad_out)
		bs <= 3'h0;
		apb(1'h1, 12'h004, 32'h0000_01A5);
		tk(2);
		`CHK("io_std", 4'h5, io_std)
		`CHK("drive", 3'h2, drive)
		`CHK("slew", 1'h1, slew_fast)
		tend("preconfig");
		c = '0;
		c.done = 1'h1;
		setc();
		`CHK("direct_o", 1'h1, pad_out)
		`CHK("direct_t", 1'h1, pad_oe)
		c.inv_o = 1'h1;
		c.inv_t = 1'h1;
		setc();
		`CHK("inv_o", 1'h0, pad_out)
		`CHK("inv_t", 1'h0, pad_oe)
		c = '0;
		c.done = 1'h1;
		c.o_reg = 1'h1;
		c.t_reg = 1'h1;
		fab.o <= 1'h0;
		fab.ce <= 3'h6;
		setc();
		fclk();
		`CHK("reg_o", 1'h0, pad_out)
		`CHK("reg_t", 1'h1, pad_oe)
		fab.o <= 1'h1;
		fab.t <= 1'h1;
		fab.ce <= 3'h4;
		fclk();
		`CHK("ce_off", 1'h0, pad_out)
		`CHK("t_sync", 1'h0, pad_oe)
		fab.ce <= 3'h6;
		fab.t <= 1'h0;
		tk(4);
		`CHK("no_edge", 1'h0, pad_out)
		fclk();
		`CHK("edge", 1'h1, pad_out)
		c.sr_mode[1] = pin_cell_pkg::SR_ASYNC_CLR;
		setc();
		fab.sr <= 1'h1;
		tk(4);
		`CHK("aclr", 1'h0, pad_out)
		c.sr_mode[1] = pin_cell_pkg::SR_SYNC_SET;
		setc();
		`CHK("sset_wait", 1'h0, pad_out)
		fclk();
		`CHK("sset", 1'h1, pad_out)
		fab.sr <= 1'h0;
		c.latch[1] = 1'h1;
		fab.clk <= 1'h1;
		fab.o <= 1'h0;
		setc();
		`CHK("latch_pass0", 1'h0, pad_out)
		fab.o <= 1'h1;
		tk(4);
		`CHK("latch_pass1", 1'h1, pad_out)
		fab.clk <= 1'h0;
		tk(4);
		fab.o <= 1'h0;
		tk(4);
		`CHK("latch_hold", 1'h1, pad_out)
		tend("output");
		c = '0;
		c.done = 1'h1;
		c.in_dly = 1'h1;
		fab.t <= 1'h1;
		fab.ce <= 3'h1;
		ext_oe <= 1'h1;
		ext_val <= 1'h1;
		setc();
		tk(2);
		`CHK("i_direct", 1'h1, fab_i.i_direct)
		fclk();
		`CHK("i_reg", 1'h1, fab_i.i_reg)
		ext_val <= 1'h0;
		tk(6);
		`CHK("i_direct", 1'h0, fab_i.i_direct)
		`CHK("i_reg_hold", 1'h1, fab_i.i_reg)
		`CHK("capture", 1'h0, bs_capture)
		c.keeper_en = 1'h1;
		ext_val <= 1'h1;
		setc();
		`CHK("keep_oe", 1'h1, keep_oe)
		ext_oe <= 1'h0;
		tk(6);
		`CHK("keep_out", 1'h1, keep_out)
		`CHK("pad_held", 1'h1, pad_in)
		c.keeper_en = 1'h0;
		c.pull_dn = 1'h1;
		c.pull_up = 1'h1;
		setc();
		`CHK("pull_dn", 1'h1, pull_dn_en)
		`CHK("pull_up", 1'h1, pull_up_en)
		tend("input");
		c = '0;
		c.done = 1'h1;
		c.o_reg = 1'h1;
		c.inv_clk = 1'h1;
		c.inv_sr = 1'h1;
		c.inv_ce = 3'h2;
		c.sr_mode[1] = pin_cell_pkg::SR_SYNC_RST;
		fab.clk <= 1'h1;
		fab.sr <= 1'h1;
		fab.ce <= 3'h0;
		fab.o <= 1'h0;
		fab.t <= 1'h0;
		setc();
		fclk();
		`CHK("inv_clk_ce", 1'h0, pad_out)
		fab.sr <= 1'h0;
		fab.o <= 1'h1;
		fclk();
		`CHK("sync_rst", 1'h0, pad_out)
		c.sr_mode[1] = pin_cell_pkg::SR_ASYNC_PRE;
		setc();
		`CHK("apre", 1'h1, pad_out)
		apb(1'h0, 12'h000, 32'h0);
		`CHK("ctrl_rb", c, rd)
		tend("control");
		give_verdict();
	end
endmodule // configurable_io_block_tb_top
